// File: rtl/adc_ctl_consts.vh
// constants for the converter control block: offsets, fields, timing
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH

// ==========================================
// register indices (byte address = index * 4)
`define IDX_RESULT 8'h1E
`define IDX_CONTROL 8'h1F
`define IDX_REFSEL 8'h9F
`define IDX_IRQ_STATUS 8'hA0
`define IDX_IRQ_MASK 8'hA1
`define IDX_ANALOG_SEL 8'hA2
`define IDX_PORT_B_DIR 8'hA3
`define IDX_PORT_A 8'hA4
`define IDX_PORT_B 8'hA5
`define IDX_CH_STATUS 8'hA6

// ==========================================
// control register fields
`define CTL_ON_BIT 0
`define CTL_SRC_BIT 1
`define CTL_GO_BIT 2
`define CTL_CHLO_LSB 3
`define CTL_CHLO_MSB 5
`define CTL_CLK_LSB 6
`define CTL_CLK_MSB 7
`define REFSEL_MASK 8'h30
`define IRQ_FLAG_BIT 6

// ==========================================
// reset values
`define CONTROL_RESET 8'h00
`define REFSEL_RESET 8'h00
`define RESULT_RESET 8'h00
`define MASK_RESET 8'h00
`define ANALOG_PIN_SELECT_RESET 8'hFF
`define DIR_RESET 8'hFF

// ==========================================
// conversion timing: 9.5 tad, counted in half tad steps
`define CONV_HALF_TADS 19
`define RC_TAD_NS 4000
`define CLK_NS 10

`endif

// File: rtl/adc_tad_gen.v
// divider making half-period conversion clock enables
`timescale 1ns/10ps
`include "adc_ctl_consts.vh"
module adc_tad_gen #(
   parameter RC_HALF_CYCLES = `RC_TAD_NS / `CLK_NS / 2
) (
   input wire clk_in,
   input wire rst_in,
   input wire run_in,
   input wire [1:0] select_in,
   output reg tick_out
);
   reg [15:0] count;
   reg [15:0] limit;

   // ==========================================
   // divider limit per clock source
   always @* begin
      case (select_in)
         2'b00: limit = 16'h0000;
         2'b01: limit = 16'h0003;
         2'b10: limit = 16'h000F;
         default: limit = RC_HALF_CYCLES[15:0] - 16'h0001;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in || !run_in) begin
         count <= 16'h0000;
         tick_out <= 1'b0;
      end else if (count >= limit) begin
         count <= 16'h0000;
         tick_out <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick_out <= 1'b0;
      end
   end
endmodule

// File: rtl/pin_sync.v
// three-stage synchroniser for a pin bus, two-stage agreement
`timescale 1ns/10ps
module pin_sync #(
   parameter WIDTH = 8
) (
   input wire clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] pins_in,
   output reg [WIDTH-1:0] level_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   // ==========================================
   // a bit changes only once stages two and three agree
   always @(posedge clk_in) begin
      if (rst_in) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         level_out <= {WIDTH{1'b0}};
      end else begin
         stage1 <= pins_in;
         stage2 <= stage1;
         stage3 <= stage2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule

// File: rtl/adc_control.v
// register side of the 8-bit converter: control, result, flags, ports
`timescale 1ns/10ps
`include "adc_ctl_consts.vh"

// Contract
// - conversion flag, control bit 2, reads one throughout a conversion
// - writing one to the conversion flag starts a conversion
// - hardware clears the conversion flag when the conversion ends
// - source bit zero selects external channel by low channel bits
// - reference field bits 5:4 of control one picks the reference
// - control one bits 7:6 and 3:0 ignore writes, read zero
// - full 8-bit value loads into the result register at the end
// - completion sets the converter flag, bit 6 of the flag register
// - with the interrupt enabled, completion also raises a request
// - result register is read-write on bits 7:0
// - analog-select bit turns off the pin's digital input buffer
// - conversion ignores direction and analog-select settings
// - port reads return zero on pins set as analog inputs
// - converter-on enables; clearing it stops any conversion at once
// - channel is control bits 5:3 low plus bit 1 as source type
// - control bits 7:6 select clock: /2, /8, /32, internal rc
module adc_control #(
   parameter RC_HALF_CYCLES = `RC_TAD_NS / `CLK_NS / 2
) (
   input wire clk_in,
   input wire rst_in,
   // apb slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   // analog core
   input wire [7:0] sample_value_in,
   output reg [3:0] channel_out,
   output reg [1:0] reference_out,
   output reg converter_on_out,
   output reg sample_out,
   // pins
   input wire [7:0] port_a_pins_in,
   input wire [7:0] port_b_pins_in,
   output reg [7:0] input_buffer_off_out,
   output reg [7:0] port_b_direction_out,
   output reg irq_out
);
   // ==========================================
   // states
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] conversion_control;
   reg [7:0] reference_select_control;
   reg [7:0] conversion_result;
   reg [7:0] irq_status;
   reg [7:0] irq_mask;
   reg [7:0] analog_pin_select;
   reg [7:0] port_b_direction;
   reg [4:0] half_tads;
   reg [31:0] next_rdata;
   reg next_err;
   reg done_pulse;

   wire [7:0] port_a_sync;
   wire [7:0] port_b_sync;
   wire tad_tick;
   wire access = psel_in && penable_in && !pready_out;
   wire [9:0] index = paddr_in[11:2];
   wire wr = access && pwrite_in && !next_err;
   wire rd = access && !pwrite_in && !next_err;
   wire converter_on = conversion_control[`CTL_ON_BIT];
   wire source_type_bit = conversion_control[`CTL_SRC_BIT];
   wire [2:0] channel_low_bits =
      conversion_control[`CTL_CHLO_MSB:`CTL_CHLO_LSB];
   wire [1:0] conv_clock_select =
      conversion_control[`CTL_CLK_MSB:`CTL_CLK_LSB];
   wire [1:0] reference_select = reference_select_control[5:4];
   wire wr_control = wr && index == {2'b00, `IDX_CONTROL};
   wire go_write = wr_control && pwdata_in[`CTL_GO_BIT]
      && pwdata_in[`CTL_ON_BIT];
   wire abort = state == ST_CONV && (!converter_on
      || (wr_control && !pwdata_in[`CTL_GO_BIT]));
   wire finish = state == ST_CONV && tad_tick
      && half_tads == 5'd`CONV_HALF_TADS - 5'd1;
   wire [7:0] irq_raise = {1'b0, finish, 6'h00};
   wire clear_status = rd && index == {2'b00, `IDX_IRQ_STATUS};

   // ==========================================
   // conversion clock and pin synchronisers
   adc_tad_gen #(
      .RC_HALF_CYCLES(RC_HALF_CYCLES)
   ) u_tad (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(state == ST_CONV),
      .select_in(conv_clock_select),
      .tick_out(tad_tick)
   );

   pin_sync #(
      .WIDTH(8)
   ) u_sync_a (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pins_in(port_a_pins_in),
      .level_out(port_a_sync)
   );

   pin_sync #(
      .WIDTH(8)
   ) u_sync_b (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pins_in(port_b_pins_in),
      .level_out(port_b_sync)
   );

   // ==========================================
   // conversion sequencer
   always @* begin
      case (state)
         ST_IDLE: begin
            // source is not checked against pin setup
            if (go_write) begin
               next_state = ST_CONV;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_CONV: begin
            if (abort || finish) begin
               next_state = ST_IDLE;
            end else begin
               next_state = ST_CONV;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         half_tads <= 5'd0;
         done_pulse <= 1'b0;
      end else begin
         state <= next_state;
         done_pulse <= finish;
         if (state != ST_CONV) begin
            half_tads <= 5'd0;
         end else if (tad_tick) begin
            half_tads <= half_tads + 5'd1;
         end
      end
   end

   // ==========================================
   // control registers
   always @(posedge clk_in) begin
      if (rst_in) begin
         conversion_control <= `CONTROL_RESET;
         reference_select_control <= `REFSEL_RESET;
         analog_pin_select <= `ANALOG_PIN_SELECT_RESET;
         port_b_direction <= `DIR_RESET;
         irq_mask <= `MASK_RESET;
      end else begin
         if (wr_control) begin
            conversion_control <= pwdata_in[7:0];
            // go only sticks when the converter is on; a write landing
            // on the last cycle must not leave go set with nothing running
            conversion_control[`CTL_GO_BIT] <= go_write && !finish
               && !abort;
         end else if (finish || abort) begin
            conversion_control[`CTL_GO_BIT] <= 1'b0;
         end
         if (wr && index == {2'b00, `IDX_REFSEL}) begin
            reference_select_control <=
               pwdata_in[7:0] & `REFSEL_MASK;
         end
         if (wr && index == {2'b00, `IDX_ANALOG_SEL}) begin
            analog_pin_select <= pwdata_in[7:0];
         end
         if (wr && index == {2'b00, `IDX_PORT_B_DIR}) begin
            port_b_direction <= pwdata_in[7:0];
         end
         if (wr && index == {2'b00, `IDX_IRQ_MASK}) begin
            irq_mask <= pwdata_in[7:0];
         end
      end
   end

   // ==========================================
   // result and sticky flags; completion wins over software
   always @(posedge clk_in) begin
      if (rst_in) begin
         conversion_result <= `RESULT_RESET;
         irq_status <= 8'h00;
      end else begin
         if (finish) begin
            conversion_result <= sample_value_in;
         end else if (wr && index == {2'b00, `IDX_RESULT}) begin
            conversion_result <= pwdata_in[7:0];
         end
         if (clear_status) begin
            irq_status <= irq_raise;
         end else begin
            irq_status <= irq_status | irq_raise;
         end
      end
   end

   // ==========================================
   // apb read mux, one wait state
   always @* begin
      next_err = 1'b0;
      next_rdata = 32'h0000_0000;
      case (index)
         {2'b00, `IDX_RESULT}: next_rdata[7:0] = conversion_result;
         {2'b00, `IDX_CONTROL}: next_rdata[7:0] = conversion_control;
         {2'b00, `IDX_REFSEL}:
            next_rdata[7:0] = reference_select_control;
         {2'b00, `IDX_IRQ_STATUS}: next_rdata[7:0] = irq_status;
         {2'b00, `IDX_IRQ_MASK}: next_rdata[7:0] = irq_mask;
         {2'b00, `IDX_ANALOG_SEL}: next_rdata[7:0] = analog_pin_select;
         {2'b00, `IDX_PORT_B_DIR}: next_rdata[7:0] = port_b_direction;
         {2'b00, `IDX_PORT_A}:
            next_rdata[7:0] = port_a_sync & ~analog_pin_select;
         {2'b00, `IDX_PORT_B}:
            next_rdata[7:0] = port_b_sync & ~analog_pin_select;
         {2'b00, `IDX_CH_STATUS}:
            next_rdata[7:0] = {4'h0, state == ST_CONV, source_type_bit,
               converter_on, done_pulse};
         default: next_err = 1'b1;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= access;
         pslverr_out <= access && next_err;
         if (access && !pwrite_in) begin
            prdata_out <= next_rdata;
         end
      end
   end

   // ==========================================
   // outputs toward the analog core and pins
   always @(posedge clk_in) begin
      if (rst_in) begin
         channel_out <= 4'h0;
         reference_out <= 2'b00;
         converter_on_out <= 1'b0;
         sample_out <= 1'b0;
         input_buffer_off_out <= `ANALOG_PIN_SELECT_RESET;
         port_b_direction_out <= `DIR_RESET;
         irq_out <= 1'b0;
      end else begin
         channel_out <= {source_type_bit, channel_low_bits};
         reference_out <= reference_select;
         converter_on_out <= converter_on;
         sample_out <= state == ST_CONV && !abort;
         input_buffer_off_out <= analog_pin_select;
         port_b_direction_out <= port_b_direction;
         irq_out <= |(irq_status & irq_mask);
      end
   end
endmodule

// File: sim/adc_control_props.sv
// port checker for the converter control block
`timescale 1ns/10ps
module adc_control_props #(
   parameter RC_HALF_CYCLES = 200
) (
   input wire clk_in,
   input wire rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire pready_out,
   input wire pslverr_out,
   input wire [3:0] channel_out,
   input wire [1:0] reference_out,
   input wire converter_on_out,
   input wire sample_out,
   input wire irq_out
);
   // ==========================================
   // helpers
   reg [9:0] high_cnt;
   reg [3:0] idle_age;
   reg wr_1;
   reg wr_2;
   always @(posedge clk_in) begin
      if (rst_in) begin
         high_cnt <= 10'h000;
         idle_age <= 4'hF;
         wr_1 <= 1'b0;
         wr_2 <= 1'b0;
      end else begin
         // saturates so a long rc conversion cannot wrap the count
         high_cnt <= !sample_out ? 10'h000 :
            (high_cnt == 10'h3FF) ? high_cnt : high_cnt + 10'h001;
         wr_1 <= psel_in & penable_in & pwrite_in;
         wr_2 <= wr_1;
         if (psel_in & penable_in)
            idle_age <= 4'h0;
         else if (idle_age != 4'hF)
            idle_age <= idle_age + 4'h1;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ==========================================
   // assertions
   pready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   one_wait_a: assert property ((psel_in && penable_in && !pready_out)
      |=> pready_out) else $error("ready not one cycle after access");
   err_pair_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   // aborts come from writes, so only unprovoked ends are timed
   busy_length_a: assert property (($fell(sample_out) && !wr_1 && !wr_2)
      |-> high_cnt >= 10'h012) else $error("conversion ended early");
   busy_start_a: assert property ($rose(sample_out) |-> wr_1 || wr_2)
      else $error("conversion began without a write");
   ref_cause_a: assert property (!$stable(reference_out) |-> wr_1)
      else $error("reference changed without a write");
   chan_cause_a: assert property (!$stable(channel_out) |-> wr_1)
      else $error("channel changed without a write");
   on_gate_a: assert property (sample_out |-> converter_on_out)
      else $error("converting while disabled");
   irq_clear_a: assert property ($fell(irq_out) |-> idle_age <= 4'h4)
      else $error("interrupt dropped with no access");
endmodule

bind adc_control adc_control_props #(.RC_HALF_CYCLES(RC_HALF_CYCLES))
   adc_control_props_i (.clk_in(clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .channel_out(channel_out), .reference_out(reference_out),
   .converter_on_out(converter_on_out), .sample_out(sample_out),
   .irq_out(irq_out));

// File: sim/adc_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`include "adc_ctl_consts.vh"
module adc_control_tb_top;
   logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, conv_on, sample, irq;
   logic [7:0] sval = 0, pa = 0, pb = 0, boff, bdir, v, r, c;
   logic [3:0] chan;
   logic [1:0] refo;
   int miscompares = 0, comparisons = 0, cycles = 0, k, run = 0, busy = 0;
   always #5 clk_in = ~clk_in;
   // short rc divide keeps the rc conversion brief; the /32 select is the slowest
   localparam int RC_HALF = 2;
   adc_control #(.RC_HALF_CYCLES(RC_HALF)) adc_control_i (.clk_in(clk_in),
      .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .sample_value_in(sval), .channel_out(chan), .reference_out(refo),
      .converter_on_out(conv_on), .sample_out(sample),
      .port_a_pins_in(pa), .port_b_pins_in(pb),
      .input_buffer_off_out(boff), .port_b_direction_out(bdir),
      .irq_out(irq));
   // ==========================================
   // checking and bus tasks
   task check(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task bus(input logic wr, input logic [7:0] idx, d);
      @(posedge clk_in);
      psel <= 1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk_in);
      penable <= 1;
      // only the bench timeout ends this wait if ready never comes
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] idx, input logic [31:0] exp, m);
      bus(0, idx, 8'h00);
      check(rd & m, exp);
   endtask
   task convert(input logic [1:0] cs);
      int n, h;
      v = $urandom;
      c = $urandom;
      sval <= v;
      bus(1, `IDX_RESULT, ~v);
      h = `CONV_HALF_TADS * half_clocks(cs);
      bus(1, `IDX_CONTROL, {cs, c[2:0], 3'b101});
      rchk(`IDX_CONTROL, 32'h4, 32'h4);
      n = 0;
      while (rd[2] && n < 200) begin
         bus(0, `IDX_CONTROL, 8'h00);
         n++;
      end
      check(rd, {cs, c[2:0], 3'b001});
      check(chan, {1'b0, c[2:0]});
      check(conv_on, 1);
      rchk(`IDX_RESULT, v, 32'hFF);
      // busy span exceeds the half tad count by one cycle, from the registered divider tick
      check(busy >= h && busy <= h + 2, 1);
      check(irq, 1);
      rchk(`IDX_IRQ_STATUS, 32'h40, 32'h40);
      repeat (2) @(posedge clk_in);
      check(irq, 0);
      rchk(`IDX_IRQ_STATUS, 0, 32'h40);
   endtask
   // length of the last busy span on the sample output
   always @(posedge clk_in) begin
      if (sample) begin
         run <= run + 1;
      end else if (run != 0) begin
         busy <= run;
         run <= 0;
      end
   end
   // half tad in clocks for each conversion clock select
   function int half_clocks(input logic [1:0] cs);
      case (cs)
         2'b00: half_clocks = 1;
         2'b01: half_clocks = 4;
         2'b10: half_clocks = 16;
         default: half_clocks = RC_HALF;
      endcase
   endfunction
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         complete_run;
      end
   end
   // ==========================================
   // main sequence
   initial begin
      k = $urandom(32'h7C1B56BA);
      repeat (6) @(posedge clk_in);
      rst_in <= 0;
      rchk(`IDX_CONTROL, 0, 32'hFFFFFFFF);
      rchk(`IDX_REFSEL, 0, 32'hFFFFFFFF);
      for (k = 0; k < 6; k++) begin
         v = $urandom;
         if (k < 4)
            v[5:4] = k[1:0];
         bus(1, `IDX_REFSEL, v);
         rchk(`IDX_REFSEL, v & 8'h30, 32'hFFFFFFFF);
         check(refo, v[5:4]);
      end
      for (k = 0; k < 2; k++) begin
         bus(1, `IDX_CONTROL, {2'b00, k[2:0], 3'b010});
         @(posedge clk_in);
         check(chan, {1'b1, k[2:0]});
         check(conv_on, 0);
      end
      $display("test registers done");
      bus(1, `IDX_IRQ_MASK, 8'h40);
      for (k = 0; k < 4; k++)
         convert(k[1:0]);
      $display("test conversions done");
      r = $urandom;
      bus(1, `IDX_RESULT, r);
      rchk(`IDX_RESULT, r, 32'hFF);
      bus(1, `IDX_CONTROL, 8'h85);
      bus(1, `IDX_CONTROL, 8'h80);
      repeat (2) @(posedge clk_in);
      check(sample, 0);
      repeat (400) @(posedge clk_in);
      rchk(`IDX_RESULT, r, 32'hFF);
      rchk(`IDX_IRQ_STATUS, 0, 32'h40);
      bus(0, 8'h50, 8'h00);
      check(err, 1);
      check(rd, 0);
      $display("test abort done");
      pa <= $urandom;
      pb <= $urandom;
      for (k = 0; k < 2; k++) begin
         v = k ? 8'h00 : 8'hFF;
         bus(1, `IDX_ANALOG_SEL, v);
         repeat (6) @(posedge clk_in);
         check(boff, v);
         rchk(`IDX_PORT_A, pa & ~v, 32'hFFFFFFFF);
         rchk(`IDX_PORT_B, pb & ~v, 32'hFFFFFFFF);
      end
      r = $urandom;
      bus(1, `IDX_PORT_B_DIR, r);
      @(posedge clk_in);
      check(bdir, r);
      $display("test pins done");
      complete_run;
   end
endmodule
